// file: src/pfs_consts.svh
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PFS_CLK_NS 50
`define PFS_TICK_NS 1000000
`define PFS_TICK_CYCLES ((`PFS_TICK_NS + `PFS_CLK_NS - 1) / `PFS_CLK_NS)

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PFS_ADDR_CTRL 8'h00
`define PFS_ADDR_REPEAT 8'h04
`define PFS_ADDR_TRIG 8'h08
`define PFS_ADDR_STATUS 8'h0c
`define PFS_ADDR_STEP_BASE 8'h40
`define PFS_ADDR_STEP_END 8'ha0

// word within a step block (addr[3:2])
`define PFS_SW_TIME 2'h0
`define PFS_SW_LEVEL 2'h1
`define PFS_SW_PHASE 2'h2
`define PFS_SW_OUT 2'h3

// ----------------------------------------
// field positions
// ----------------------------------------
`define PFS_CTRL_START 0
`define PFS_CTRL_EXIT 1
`define PFS_CTRL_REPEAT 2
`define PFS_TRIG_POL 0
`define PFS_TRIG_W_LSB 8
`define PFS_PH_START_EN 10
`define PFS_PH_STOP_LSB 16
`define PFS_PH_STOP_EN 26
`define PFS_OUT_TRIG 2
`define PFS_LVL_FREQ_LSB 16

// ----------------------------------------
// values
// ----------------------------------------
`define PFS_REPEAT_MAX 14'h270f
`define PFS_TRIG_W_RST 8'h14
`define PFS_TRIG_POL_RST 1'b1
`define PFS_STEP_INIT 3'h0
`define PFS_STEP_N1 3'h1
`define PFS_STEP_T1 3'h2
`define PFS_STEP_AB 3'h3
`define PFS_STEP_T2 3'h4
`define PFS_STEP_N2 3'h5
`define PFS_NUM_STEPS 6

`endif

// file: src/pfs_pkg.sv
package pfs_pkg;

  typedef enum logic [5:0] {
    PFS_ST_INIT = 6'h01,
    PFS_ST_N1 = 6'h02,
    PFS_ST_T1 = 6'h04,
    PFS_ST_AB = 6'h08,
    PFS_ST_T2 = 6'h10,
    PFS_ST_N2 = 6'h20
  } pfs_step_t;

  typedef logic [31:0] pfs_word_t;

endpackage

// file: src/pfs_ramp.sv
`timescale 1ns/1ps
`default_nettype none

module pfs_ramp #(
  parameter int W = 16,
  parameter int TW = 24
) (
  input wire logic clk,              // system clock
  input wire logic reset_n,          // async reset
  input wire logic load,             // start a new ramp
  input wire logic [W-1:0] start_val, // value at ramp start
  input wire logic [W-1:0] target_val, // value at ramp end
  input wire logic [TW-1:0] span,    // ramp length in ticks
  input wire logic tick,             // timebase tick
  output logic [W-1:0] value         // current ramp value
);

  localparam int EW = TW + W + 1;

  logic [W-1:0] tgt_reg;
  logic [W-1:0] diff_reg;
  logic [EW-1:0] span_reg;
  logic [EW-1:0] err_reg;
  logic up_reg;
  logic step;
  logic moving;

  // -------------------------------------
  // error-accumulating line drawing
  // -------------------------------------
  // no divider: each tick adds |delta|, each cycle one lsb is paid off per span;
  // tracks exactly while |delta|/span stays below the cycles of one tick
  assign moving = (value != tgt_reg);
  assign step = moving && (err_reg >= span_reg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      value <= '0;
      tgt_reg <= '0;
      diff_reg <= '0;
      span_reg <= EW'(1);
      err_reg <= '0;
      up_reg <= 1'b1;
    end else if (load) begin
      value <= start_val;
      tgt_reg <= target_val;
      up_reg <= (target_val >= start_val);
      diff_reg <= (target_val >= start_val) ? W'(target_val - start_val) : W'(start_val - target_val);
      span_reg <= (span == '0) ? EW'(1) : EW'(span);
      err_reg <= '0;
    end else begin
      err_reg <= EW'(err_reg + ((tick && moving) ? EW'(diff_reg) : EW'(0)) - (step ? span_reg : EW'(0)));
      if (step) begin
        value <= up_reg ? W'(value + W'(1)) : W'(value - W'(1));
      end
    end
  end

endmodule

`default_nettype wire

// file: src/pfs_sequencer.sv
// The implementer's own choices: strobed register access and the register offsets.
`include "pfs_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pfs_sequencer #(
  parameter int TICK_CYCLES = `PFS_TICK_CYCLES
) (
  input wire logic clk,                          // 20 MHz clock
  input wire logic reset_n,                      // async reset, active low
  input wire logic [7:0] reg_addr,               // register byte address
  input wire logic [31:0] reg_wdata,             // write data
  input wire logic reg_wr,                       // write strobe
  input wire logic reg_rd,                       // read strobe
  output pfs_pkg::pfs_word_t reg_rdata,          // read data, cycle after strobe
  input wire logic [9:0] phase_in,               // synthesizer phase, same clock
  output logic [15:0] volt_out,                  // voltage target
  output logic [15:0] freq_out,                  // frequency target
  output logic phase_load,                       // load start phase pulse
  output logic [9:0] phase_load_val,             // start phase value
  output logic [1:0] sync_code,                  // step sync code pins
  output logic trig_out,                         // trigger pin
  output pfs_pkg::pfs_step_t step_out,           // current step
  output logic sim_running,                      // run in progress
  output logic internal_combined_source_setting, // fixed source and mode
  output logic balanced_mode                     // polyphase balanced
);

  import pfs_pkg::*;

  // ----------------------------------------
  // step settings
  // ----------------------------------------
  logic [23:0] time_reg [`PFS_NUM_STEPS];
  logic [15:0] volt_reg [`PFS_NUM_STEPS];
  logic [15:0] freq_reg [`PFS_NUM_STEPS];
  logic [9:0] sph_reg [`PFS_NUM_STEPS];
  logic [9:0] qph_reg [`PFS_NUM_STEPS];
  logic [`PFS_NUM_STEPS-1:0] sen_reg, qen_reg, trg_reg;
  logic [1:0] code_reg [`PFS_NUM_STEPS];
  logic repeat_en_reg, trig_pol_reg;
  logic [13:0] repeat_cnt_reg;
  logic [7:0] trig_w_reg;
  pfs_step_t state_reg, state_next;
  logic enter_reg, wait_stop_reg, tick;
  logic [13:0] pass_reg;
  logic [23:0] tleft_reg;
  logic [$clog2(TICK_CYCLES)-1:0] tb_reg;
  logic [7:0] trig_cnt_reg;
  logic in_step_blk, start_cmd, exit_cmd, expired, phase_hit, step_done, more_passes, ramp_load;
  logic [2:0] wsel, cur, nxt;
  logic [15:0] ramp_v_from, ramp_v_to, ramp_f_from, ramp_f_to, ramp_v, ramp_f;

  function automatic logic [2:0] idx_of(input pfs_step_t s);
    case (s)
      PFS_ST_N1: idx_of = `PFS_STEP_N1;
      PFS_ST_T1: idx_of = `PFS_STEP_T1;
      PFS_ST_AB: idx_of = `PFS_STEP_AB;
      PFS_ST_T2: idx_of = `PFS_STEP_T2;
      PFS_ST_N2: idx_of = `PFS_STEP_N2;
      default: idx_of = `PFS_STEP_INIT;
    endcase
  endfunction
  // level source: Normal 2 borrows Normal 1
  function automatic logic [2:0] lvl_of(input logic [2:0] i);
    lvl_of = (i == `PFS_STEP_N2) ? `PFS_STEP_N1 : i;
  endfunction
  function automatic logic phase_ok(input logic [2:0] i);
    phase_ok = (i == `PFS_STEP_N1) || (i == `PFS_STEP_AB) || (i == `PFS_STEP_N2);
  endfunction
  function automatic logic level_ok(input logic [2:0] i);
    level_ok = (i == `PFS_STEP_INIT) || (i == `PFS_STEP_N1) || (i == `PFS_STEP_AB);
  endfunction

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  assign in_step_blk = (reg_addr >= `PFS_ADDR_STEP_BASE) && (reg_addr < `PFS_ADDR_STEP_END);
  assign wsel = 3'(reg_addr[7:4] - 4'h4);
  assign start_cmd = reg_wr && (reg_addr == `PFS_ADDR_CTRL) && reg_wdata[`PFS_CTRL_START];
  assign exit_cmd = reg_wr && (reg_addr == `PFS_ADDR_CTRL) && reg_wdata[`PFS_CTRL_EXIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      repeat_en_reg <= 1'b0;
      repeat_cnt_reg <= 14'h0001;
      trig_pol_reg <= `PFS_TRIG_POL_RST;
      trig_w_reg <= `PFS_TRIG_W_RST;
    end else if (reg_wr) begin
      if (reg_addr == `PFS_ADDR_CTRL) begin
        repeat_en_reg <= reg_wdata[`PFS_CTRL_REPEAT];
      end else if (reg_addr == `PFS_ADDR_REPEAT) begin
        // out-of-range counts in bits 15:0 saturate rather than wrap; bits 31:16 are ignored
        repeat_cnt_reg <= (reg_wdata[15:0] > 16'(`PFS_REPEAT_MAX)) ? `PFS_REPEAT_MAX : reg_wdata[13:0];
      end else if (reg_addr == `PFS_ADDR_TRIG) begin
        trig_pol_reg <= reg_wdata[`PFS_TRIG_POL];
        trig_w_reg <= reg_wdata[`PFS_TRIG_W_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `PFS_NUM_STEPS; i++) begin
        time_reg[i] <= '0;
        volt_reg[i] <= '0;
        freq_reg[i] <= '0;
        sph_reg[i] <= '0;
        qph_reg[i] <= '0;
        code_reg[i] <= '0;
      end
      sen_reg <= '0;
      qen_reg <= '0;
      trg_reg <= '0;
    end else if (reg_wr && in_step_blk) begin
      if (reg_addr[3:2] == `PFS_SW_TIME) begin
        if (wsel != `PFS_STEP_INIT) begin
          time_reg[wsel] <= reg_wdata[23:0];
        end
      end else if (reg_addr[3:2] == `PFS_SW_LEVEL) begin
        if (level_ok(wsel)) begin
          volt_reg[wsel] <= reg_wdata[15:0];
          freq_reg[wsel] <= reg_wdata[`PFS_LVL_FREQ_LSB +: 16];
        end
      end else if (reg_addr[3:2] == `PFS_SW_PHASE) begin
        if (phase_ok(wsel)) begin
          sph_reg[wsel] <= reg_wdata[9:0];
          sen_reg[wsel] <= reg_wdata[`PFS_PH_START_EN];
          qph_reg[wsel] <= reg_wdata[`PFS_PH_STOP_LSB +: 10];
          qen_reg[wsel] <= reg_wdata[`PFS_PH_STOP_EN];
        end
      end else begin
        code_reg[wsel] <= reg_wdata[1:0];
        if (wsel != `PFS_STEP_INIT) begin
          trg_reg[wsel] <= reg_wdata[`PFS_OUT_TRIG];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == `PFS_ADDR_CTRL) begin
        reg_rdata <= 32'(repeat_en_reg) << `PFS_CTRL_REPEAT;
      end else if (reg_addr == `PFS_ADDR_REPEAT) begin
        reg_rdata <= 32'(repeat_cnt_reg);
      end else if (reg_addr == `PFS_ADDR_TRIG) begin
        reg_rdata <= (32'(trig_w_reg) << `PFS_TRIG_W_LSB) | 32'(trig_pol_reg);
      end else if (reg_addr == `PFS_ADDR_STATUS) begin
        reg_rdata <= {pass_reg, 10'h000, wait_stop_reg, sim_running, state_reg};
      end else if (in_step_blk && reg_addr[3:2] == `PFS_SW_TIME) begin
        reg_rdata <= 32'(time_reg[wsel]);
      end else if (in_step_blk && reg_addr[3:2] == `PFS_SW_LEVEL) begin
        reg_rdata <= {freq_reg[wsel], volt_reg[wsel]};
      end else if (in_step_blk && reg_addr[3:2] == `PFS_SW_PHASE) begin
        reg_rdata <= {5'h00, qen_reg[wsel], qph_reg[wsel], 5'h00, sen_reg[wsel], sph_reg[wsel]};
      end else if (in_step_blk) begin
        reg_rdata <= {29'h0, trg_reg[wsel], code_reg[wsel]};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------
  // timebase and step timer
  // ----------------------------------------
  assign tick = (tb_reg == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tb_reg <= '0;
    end else begin
      tb_reg <= tick ? '0 : tb_reg + 1'b1;
    end
  end
  assign cur = idx_of(state_reg);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tleft_reg <= '0;
    end else if (enter_reg) begin
      tleft_reg <= time_reg[cur];
    end else if (tick && tleft_reg != '0) begin
      tleft_reg <= tleft_reg - 1'b1;
    end
  end
  // entry cycle still holds the previous count, so it never counts as expiry
  assign expired = !enter_reg && (tleft_reg == '0);
  assign phase_hit = (phase_in == qph_reg[cur]);
  // transitions cannot gate on phase since qen is never set for them
  assign step_done = expired && (!qen_reg[cur] || phase_hit);
  assign more_passes = repeat_en_reg && ((repeat_cnt_reg == '0) || (pass_reg < repeat_cnt_reg));

  // ----------------------------------------
  // step state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PFS_ST_INIT: if (start_cmd) state_next = PFS_ST_N1;
      PFS_ST_N1: if (step_done) state_next = PFS_ST_T1;
      PFS_ST_T1: if (step_done) state_next = PFS_ST_AB;
      PFS_ST_AB: if (step_done) state_next = PFS_ST_T2;
      PFS_ST_T2: if (step_done) state_next = PFS_ST_N2;
      PFS_ST_N2: if (step_done) state_next = more_passes ? PFS_ST_N1 : PFS_ST_INIT;
      default: state_next = PFS_ST_INIT;
    endcase
    if (exit_cmd && state_reg != PFS_ST_INIT) begin
      state_next = PFS_ST_INIT;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PFS_ST_INIT;
      enter_reg <= 1'b0;
      wait_stop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      enter_reg <= (state_next != state_reg);
      wait_stop_reg <= (state_next == state_reg) && expired && qen_reg[cur] && !phase_hit;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pass_reg <= '0;
    end else if (state_reg == PFS_ST_INIT) begin
      pass_reg <= '0;
    end else if (state_reg == PFS_ST_N2 && state_next == PFS_ST_N1 && pass_reg != 14'h3fff) begin
      pass_reg <= pass_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // transition ramps
  // ----------------------------------------
  assign nxt = idx_of(state_next);
  assign ramp_load = (state_next != state_reg) && (state_next == PFS_ST_T1 || state_next == PFS_ST_T2);
  assign ramp_v_from = (state_next == PFS_ST_T1) ? volt_reg[`PFS_STEP_N1] : volt_reg[`PFS_STEP_AB];
  assign ramp_v_to = (state_next == PFS_ST_T1) ? volt_reg[`PFS_STEP_AB] : volt_reg[`PFS_STEP_N1];
  assign ramp_f_from = (state_next == PFS_ST_T1) ? freq_reg[`PFS_STEP_N1] : freq_reg[`PFS_STEP_AB];
  assign ramp_f_to = (state_next == PFS_ST_T1) ? freq_reg[`PFS_STEP_AB] : freq_reg[`PFS_STEP_N1];

  pfs_ramp #(.W(16), .TW(24)) u_ramp_volt (
    .clk(clk),
    .reset_n(reset_n),
    .load(ramp_load),
    .start_val(ramp_v_from),
    .target_val(ramp_v_to),
    .span(time_reg[nxt]),
    .tick(tick),
    .value(ramp_v)
  );

  pfs_ramp #(.W(16), .TW(24)) u_ramp_freq (
    .clk(clk),
    .reset_n(reset_n),
    .load(ramp_load),
    .start_val(ramp_f_from),
    .target_val(ramp_f_to),
    .span(time_reg[nxt]),
    .tick(tick),
    .value(ramp_f)
  );

  // ----------------------------------------
  // output levels and codes
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      volt_out <= '0;
      freq_out <= '0;
    end else if ((state_reg == PFS_ST_T1 || state_reg == PFS_ST_T2) && time_reg[cur] != '0) begin
      volt_out <= ramp_v;
      freq_out <= ramp_f;
    end else if (state_reg == PFS_ST_T1 || state_reg == PFS_ST_T2) begin
      volt_out <= volt_reg[(state_reg == PFS_ST_T1) ? `PFS_STEP_AB : `PFS_STEP_N1];
      freq_out <= freq_reg[(state_reg == PFS_ST_T1) ? `PFS_STEP_AB : `PFS_STEP_N1];
    end else begin
      volt_out <= volt_reg[lvl_of(cur)];
      freq_out <= freq_reg[lvl_of(cur)];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_code <= '0;
      step_out <= PFS_ST_INIT;
      sim_running <= 1'b0;
      phase_load <= 1'b0;
      phase_load_val <= '0;
    end else begin
      sync_code <= code_reg[nxt];
      step_out <= state_next;
      sim_running <= (state_next != PFS_ST_INIT);
      // without a load the synthesizer keeps its phase running
      phase_load <= (state_next != state_reg) && sen_reg[nxt];
      phase_load_val <= sph_reg[nxt];
    end
  end

  // ----------------------------------------
  // trigger pulse
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_cnt_reg <= '0;
    end else if (state_next != state_reg && state_next != PFS_ST_INIT && trg_reg[nxt]) begin
      trig_cnt_reg <= (trig_w_reg == '0) ? 8'h01 : trig_w_reg;
    end else if (trig_cnt_reg != '0) begin
      trig_cnt_reg <= trig_cnt_reg - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_out <= ~`PFS_TRIG_POL_RST;
    end else begin
      trig_out <= (trig_cnt_reg != '0) ? trig_pol_reg : ~trig_pol_reg;
    end
  end

  // ----------------------------------------
  // fixed simulation mode
  // ----------------------------------------
  // held here only, never written into the continuous or sequence settings
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      internal_combined_source_setting <= 1'b1;
      balanced_mode <= 1'b1;
    end else begin
      internal_combined_source_setting <= 1'b1;
      balanced_mode <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: verif/pfs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_checker (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset
  input wire logic [7:0] reg_addr, // address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic phase_load, // phase jump
  input wire logic [1:0] sync_code, // code pins
  input wire logic trig_out, // trigger pin
  input wire pfs_pkg::pfs_step_t step_out, // step
  input wire logic sim_running, // running
  input wire logic internal_combined_source_setting, // fixed mode
  input wire logic balanced_mode // balanced
);
  import pfs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // control writes
  // ----------------------------------------
  sequence s_ctl_wr; reg_wr && reg_addr == 8'h00; endsequence
  sequence s_start; s_ctl_wr ##0 (reg_wdata[0] && !reg_wdata[1]); endsequence
  sequence s_exit; s_ctl_wr ##0 (reg_wdata[1] && sim_running); endsequence
  property p_fixed; internal_combined_source_setting && balanced_mode; endproperty
  property p_running; sim_running == (step_out != PFS_ST_INIT); endproperty
  property p_order;
    $changed(step_out) && step_out != PFS_ST_INIT |->
      step_out == ($past(step_out) << 1) || (step_out == PFS_ST_N1 && $past(step_out) == PFS_ST_N2);
  endproperty
  property p_start; s_start ##0 step_out == PFS_ST_INIT |=> step_out == PFS_ST_N1 && sim_running; endproperty
  property p_exit; s_exit |=> step_out == PFS_ST_INIT; endproperty
  property p_idle;
    step_out == PFS_ST_INIT && !(reg_wr && reg_addr == 8'h00 && reg_wdata[0]) |=> step_out == PFS_ST_INIT;
  endproperty
  // a pulse may only follow a fresh entry into a step other than Initial
  property p_trig;
    $rose(trig_out) |-> $past(step_out) != PFS_ST_INIT && $past(step_out) != $past(step_out, 2);
  endproperty
  property p_phase; phase_load |-> $changed(step_out) && step_out inside {PFS_ST_N1, PFS_ST_AB, PFS_ST_N2}; endproperty
  // writes may legally retune the code, so they are kept out
  property p_code; $stable(step_out) && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(sync_code); endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode outputs low");
  a_running: assert property (p_running) else $error("running flag wrong");
  a_order: assert property (p_order) else $error("step order broken");
  a_start: assert property (p_start) else $error("start did not enter first step");
  a_exit: assert property (p_exit) else $error("exit did not return to idle");
  a_idle: assert property (p_idle) else $error("idle step left without start");
  a_trig: assert property (p_trig) else $error("trigger without step entry");
  a_phase: assert property (p_phase) else $error("phase jump in wrong step");
  a_code: assert property (p_code) else $error("code changed within a step");
endmodule
bind pfs_sequencer pfs_checker i_pfs_checker (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .phase_load,
  .sync_code, .trig_out, .step_out, .sim_running, .internal_combined_source_setting, .balanced_mode);
`default_nettype wire

// file: verif/pfs_synth_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfs_synth_model (
  input wire logic clk, // clock
  input wire logic reset_n, // async reset
  input wire logic phase_load, // jump request
  input wire logic [9:0] phase_load_val, // jump target
  output logic [9:0] phase_in // running phase
);
  // one phase step per clock keeps stop-phase waits short
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_in <= 10'h000;
    end else if (phase_load) begin
      phase_in <= phase_load_val;
    end else begin
      phase_in <= phase_in + 10'h001;
    end
  end
endmodule
`default_nettype wire

// file: verif/pfs_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s exp %0h got %0h", n, e, g); end end
module pfs_sequencer_bench;
  import pfs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  pfs_word_t reg_rdata;
  logic [9:0] phase_in, phase_load_val;
  logic [15:0] volt_out, freq_out, v_n2, v_t2;
  logic [1:0] sync_code, s_ab;
  logic phase_load, trig_out, sim_running, src_fixed, bal;
  logic trig_q = 1'b0;
  pfs_step_t step_out, last = PFS_ST_INIT;
  pfs_step_t q[$];
  pfs_step_t st[5] = '{PFS_ST_N1, PFS_ST_T1, PFS_ST_AB, PFS_ST_T2, PFS_ST_N2};
  int n_mismatch = 0, checked = 0, n_trig = 0, n_ab = 0, k;
  logic [7:0] ta[17] = '{8'h08, 8'h44, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60, 8'h6c, 8'h70, 8'h74, 8'h78,
    8'h7c, 8'h80, 8'h8c, 8'h90, 8'h9c};
  logic [31:0] td[17] = '{32'h201, 32'h320010, 32'h6, 32'h2, 32'h320064, 32'h400, 32'h5, 32'h0, 32'h2, 32'h1,
    32'h320046, 32'h0, 32'h7, 32'h0, 32'h0, 32'h1, 32'h1};
  always #25 clk = ~clk;
  pfs_sequencer #(.TICK_CYCLES(4)) i_pfs_sequencer (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .phase_in, .volt_out, .freq_out, .phase_load, .phase_load_val, .sync_code, .trig_out,
    .step_out, .sim_running, .internal_combined_source_setting(src_fixed), .balanced_mode(bal));
  pfs_synth_model i_pfs_synth_model (.clk, .reset_n, .phase_load, .phase_load_val, .phase_in);
  // ----------------------------------------
  // monitor
  // ----------------------------------------
  // sampled mid-cycle, so every step including the final idle one is seen settled
  always @(negedge clk) begin
    if (step_out !== last) begin
      q.push_back(step_out);
      last = step_out;
    end
    if (step_out == PFS_ST_AB) begin
      n_ab++;
      s_ab = sync_code;
    end
    if (step_out == PFS_ST_N2) v_n2 = volt_out;
    if (step_out == PFS_ST_T2) v_t2 = volt_out;
    if (trig_out && !trig_q) n_trig++;
    trig_q = trig_out;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input pfs_word_t e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata)
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic run(input logic [31:0] ctl, input int passes);
    q.delete();
    n_trig = 0;
    n_ab = 0;
    wr(8'h00, ctl);
    for (k = 0; k < 4000 && (k < 2 || sim_running); k++) begin
      @(negedge clk);
      #1;
    end
    if (sim_running) begin
      n_mismatch++;
      results();
    end
    `CHK("series", passes * 5 + 1, q.size())
    for (k = 0; k < q.size(); k++) `CHK("step", (k == q.size() - 1) ? PFS_ST_INIT : st[k % 5], q[k])
    `CHK("triggers", passes * 2, n_trig)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ta[i]) wr(ta[i], td[i]);
    repeat (3) @(posedge clk);
    #1;
    `CHK("idle step", PFS_ST_INIT, step_out)
    `CHK("idle volt", 16'h0010, volt_out)
    `CHK("idle code", 2'h2, sync_code)
    `CHK("fixed", 2'h3, {src_fixed, bal})
    `CHK("idle freq", 16'h0032, freq_out)
    rd(8'h0c, 32'h1);
    wr(8'h04, 32'h2710);
    rd(8'h04, 32'h270f);
    rd(8'hfc, 32'h0);
    run(32'h1, 1);
    `CHK("ab code", 2'h3, s_ab)
    `CHK("n2 volt", 16'h0064, v_n2)
    `CHK("ab short", 1'b1, n_ab < 20)
    wr(8'h04, 32'h1);
    wr(8'h80, 32'h2);
    run(32'h5, 2);
    `CHK("ramp mid", 1'b1, v_t2 > 16'h0046 && v_t2 < 16'h0064)
    wr(8'h04, 32'h0);
    wr(8'h78, 32'h0600_0000);
    q.delete();
    n_ab = 0;
    wr(8'h00, 32'h5);
    repeat (1500) @(posedge clk);
    #1;
    `CHK("endless", 1'b1, sim_running && q.size() > 6)
    `CHK("ab held", 1'b1, n_ab > 100)
    wr(8'h00, 32'h6);
    #1;
    `CHK("exit", PFS_ST_INIT, step_out)
    results();
  end
endmodule
`default_nettype wire
